// File: rtl/stw_timer.sv
// stw_timer: tick, tone and watchdog timer channels behind byte i/o ports
// assumes one-cycle read and write strobes synchronous to ref_clk_i
`timescale 1ns/1ns

module stw_timer (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // byte i/o port access
  input  wire logic [15:0] io_addr_i,
  input  wire logic [7:0]  io_wdata_i,
  input  wire logic        io_wr_i,
  input  wire logic        io_rd_i,
  output logic      [7:0]  io_rdata_o,
  // interrupt acknowledge
  input  wire logic        inta_i,
  input  wire logic [7:0]  inta_vector_i,
  // watchdog software enable
  input  wire logic        wdog_en_i,
  // system outputs
  output logic             tick_irq_o,
  output logic             nmi_o,
  output logic             write_block_o,
  output logic             audio_o,
  output logic             wdog_timeout_o
);
  import stw_pkg::*;

  // ==========================================================
  // declarations
  logic [16:0] acc;
  logic        tstep;
  logic [1:0]  sys_b;
  logic        irq;
  logic        block;
  logic        timeout;
  logic        out0;
  logic        out2;
  logic        out3;
  logic        out0_q;
  logic        out3_q;
  logic        out0_rise;
  logic [7:0]  rd0;
  logic [7:0]  rd2;
  logic [7:0]  rd3;
  logic        hit_c0;
  logic        hit_c2;
  logic        hit_c3;
  logic        hit_cw;
  logic        hit_wcw;
  logic        hit_b;
  logic        hit_a;
  logic [1:0]  cw_sel;
  logic [1:0]  cw_rw;
  stw_ctrl_t   cw;
  stw_ctrl_t   wcw;
  logic        cw0_wr;
  logic        cw2_wr;
  logic        cw3_wr;
  logic        lat0;
  logic        lat2;
  logic        lat3;
  logic        irq_clr;

  // ==========================================================
  // port decode
  assign hit_c0  = io_addr_i == TICK_COUNT_PORT;
  assign hit_c2  = io_addr_i == TONE_COUNT_PORT;
  assign hit_c3  = io_addr_i == WDOG_COUNT_PORT;
  assign hit_cw  = io_addr_i == TICK_TONE_CTRL_PORT;
  assign hit_wcw = io_addr_i == WDOG_CTRL_PORT;
  assign hit_b   = io_addr_i == SYS_CTRL_B_PORT;
  assign hit_a   = io_addr_i == SYS_CTRL_A_PORT;

  // control word split and counter select
  assign cw_sel  = io_wdata_i[CW_SEL_LSB +: 2];
  assign cw_rw   = io_wdata_i[CW_RW_LSB +: 2];
  assign cw      = '{rw:   cw_rw,
                     mode: io_wdata_i[CW_MODE_LSB +: 3],
                     bcd:  io_wdata_i[CW_BCD_BIT]};
  assign wcw     = '{rw: RW_LOW, mode: MODE_TERM, bcd: 1'b0};

  // control words and latch commands, tick/watchdog control words blocked
  assign cw0_wr  = io_wr_i && hit_cw && cw_sel == SEL_TICK &&
                   cw_rw != RW_LATCH && !block;
  assign cw2_wr  = io_wr_i && hit_cw && cw_sel == SEL_TONE &&
                   cw_rw != RW_LATCH;
  assign cw3_wr  = io_wr_i && hit_wcw && cw_sel == SEL_WDOG &&
                   cw_rw == RW_LOW && !block;
  assign lat0    = io_wr_i && hit_cw && cw_sel == SEL_TICK &&
                   cw_rw == RW_LATCH;
  assign lat2    = io_wr_i && hit_cw && cw_sel == SEL_TONE &&
                   cw_rw == RW_LATCH;
  assign lat3    = io_wr_i && hit_wcw && cw_sel == SEL_WDOG &&
                   cw_rw == RW_LATCH;

  // ==========================================================
  // 1.193 MHz counting clock from the reference
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc   <= 17'h00000;
      tstep <= 1'b0;
    end else if (acc + ACC_STEP >= ACC_WRAP) begin
      acc   <= acc + ACC_STEP - ACC_WRAP;
      tstep <= 1'b1;
    end else begin
      acc   <= acc + ACC_STEP;
      tstep <= 1'b0;
    end
  end

  // ==========================================================
  // counter channels
  stw_counter u_tick (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .step_i    (tstep),
    .gate_i    (1'b1),
    .out_o     (out0),
    .ctrl_wr_i (cw0_wr),
    .ctrl_i    (cw),
    .latch_i   (lat0),
    .data_wr_i (io_wr_i && hit_c0 && !block),
    .data_i    (io_wdata_i),
    .data_rd_i (io_rd_i && hit_c0),
    .rdata_o   (rd0)
  );

  stw_counter u_tone (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .step_i    (tstep),
    .gate_i    (sys_b[B_TONE_GATE]),
    .out_o     (out2),
    .ctrl_wr_i (cw2_wr),
    .ctrl_i    (cw),
    .latch_i   (lat2),
    .data_wr_i (io_wr_i && hit_c2),
    .data_i    (io_wdata_i),
    .data_rd_i (io_rd_i && hit_c2),
    .rdata_o   (rd2)
  );

  // falling edge of the inverted tick output is its rising edge
  stw_counter u_wdog (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .step_i    (out0_rise),
    .gate_i    (irq),
    .out_o     (out3),
    .ctrl_wr_i (cw3_wr),
    .ctrl_i    (wcw),
    .latch_i   (lat3),
    .data_wr_i (io_wr_i && hit_c3 && !block),
    .data_i    (io_wdata_i),
    .data_rd_i (io_rd_i && hit_c3),
    .rdata_o   (rd3)
  );

  // ==========================================================
  // edge detection of channel outputs
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out0_q <= 1'b1;
      out3_q <= 1'b1;
    end else begin
      out0_q <= out0;
      out3_q <= out3;
    end
  end

  assign out0_rise = out0 && !out0_q;

  // ==========================================================
  // system control port b: gate and speaker enable
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sys_b <= SYS_B_RESET;
    end else if (io_wr_i && hit_b) begin
      sys_b <= io_wdata_i[B_SPKR_EN:B_TONE_GATE];
    end
  end

  // ==========================================================
  // tick interrupt latch, set wins over clear
  assign irq_clr = (inta_i && inta_vector_i == TICK_VECTOR) ||
                   (io_wr_i && hit_b && io_wdata_i[B_IRQ_CLEAR]);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq <= 1'b0;
    end else if (out0_rise) begin
      irq <= 1'b1;
    end else if (irq_clr) begin
      irq <= 1'b0;
    end
  end

  // ==========================================================
  // write block: request still pending at a later tick rise
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      block <= 1'b0;
    end else if (!wdog_en_i || (irq_clr && !out0_rise)) begin
      block <= 1'b0;
    end else if (out0_rise && irq) begin
      block <= 1'b1;
    end
  end

  // ==========================================================
  // watchdog timeout status
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timeout <= 1'b0;
    end else if (wdog_en_i && out3 && !out3_q) begin
      timeout <= 1'b1;
    end else if (!wdog_en_i) begin
      timeout <= 1'b0;
    end
  end

  // ==========================================================
  // registered outputs
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_irq_o     <= 1'b0;
      nmi_o          <= 1'b0;
      write_block_o  <= 1'b0;
      audio_o        <= 1'b0;
      wdog_timeout_o <= 1'b0;
    end else begin
      tick_irq_o     <= irq;
      nmi_o          <= wdog_en_i && out3;
      write_block_o  <= block && wdog_en_i;
      audio_o        <= out2 && sys_b[B_SPKR_EN];
      wdog_timeout_o <= timeout;
    end
  end

  // ==========================================================
  // read data
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      io_rdata_o <= RDATA_RESET;
    end else if (io_rd_i) begin
      io_rdata_o <= RDATA_RESET;
      if (hit_c0) begin
        io_rdata_o <= rd0;
      end else if (hit_c2) begin
        io_rdata_o <= rd2;
      end else if (hit_c3) begin
        io_rdata_o <= rd3;
      end else if (hit_b) begin
        io_rdata_o[B_TONE_OUT]             <= out2;
        io_rdata_o[B_SPKR_EN:B_TONE_GATE]  <= sys_b;
      end else if (hit_a) begin
        io_rdata_o[A_WDOG_TIMEOUT] <= timeout;
      end
    end
  end

endmodule : stw_timer

// File: common/stw_pkg.sv
// stw_pkg: constants and types of the system timer and watchdog block
// assumes byte-wide i/o accesses with a 16-bit port address
package stw_pkg;

  // ==========================================================
  // i/o port addresses
  localparam logic [15:0] TICK_COUNT_PORT      = 16'h0040;
  localparam logic [15:0] TONE_COUNT_PORT      = 16'h0042;
  localparam logic [15:0] TICK_TONE_CTRL_PORT  = 16'h0043;
  localparam logic [15:0] WDOG_COUNT_PORT      = 16'h0044;
  localparam logic [15:0] WDOG_CTRL_PORT       = 16'h0047;
  localparam logic [15:0] SYS_CTRL_B_PORT      = 16'h0061;
  localparam logic [15:0] SYS_CTRL_A_PORT      = 16'h0092;

  // ==========================================================
  // control word fields
  localparam int          CW_SEL_LSB     = 6;
  localparam int          CW_RW_LSB      = 4;
  localparam int          CW_MODE_LSB    = 1;
  localparam int          CW_BCD_BIT     = 0;
  localparam logic [1:0]  SEL_TICK       = 2'h0;
  localparam logic [1:0]  SEL_TONE       = 2'h2;
  localparam logic [1:0]  SEL_WDOG       = 2'h0;
  localparam logic [1:0]  RW_LATCH       = 2'h0;
  localparam logic [1:0]  RW_LOW         = 2'h1;
  localparam logic [1:0]  RW_HIGH        = 2'h2;
  localparam logic [1:0]  RW_BOTH        = 2'h3;
  localparam logic [2:0]  MODE_TERM      = 3'h0;
  localparam logic [2:0]  MODE_ONESHOT   = 3'h1;
  localparam logic [2:0]  MODE_RATE      = 3'h2;
  localparam logic [2:0]  MODE_SQUARE    = 3'h3;
  localparam logic [2:0]  MODE_SW_STROBE = 3'h4;
  localparam logic [2:0]  MODE_HW_STROBE = 3'h5;

  // ==========================================================
  // system control port bits
  localparam int          B_TONE_GATE    = 0;
  localparam int          B_SPKR_EN      = 1;
  localparam int          B_TONE_OUT     = 5;
  localparam int          B_IRQ_CLEAR    = 7;
  localparam int          A_WDOG_TIMEOUT = 4;
  localparam logic [7:0]  TICK_VECTOR    = 8'h08;

  // ==========================================================
  // reset values
  localparam logic [1:0]  SYS_B_RESET    = 2'h0;
  localparam logic [7:0]  RDATA_RESET    = 8'h00;

  // ==========================================================
  // timer clock derived from the reference clock
  localparam int          REF_PERIOD_NS  = 10;
  localparam int          TIMER_KHZ      = 1193;
  localparam int          REF_KHZ        = 1000000 / REF_PERIOD_NS;
  localparam logic [16:0] ACC_STEP       = 17'(TIMER_KHZ);
  localparam logic [16:0] ACC_WRAP       = 17'(REF_KHZ);

  // ==========================================================
  // counter programming carrier
  typedef struct packed {
    logic [1:0] rw;
    logic [2:0] mode;
    logic       bcd;
  } stw_ctrl_t;

endpackage : stw_pkg

// File: rtl/stw_counter.sv
// stw_counter: one presettable down counter with latch and byte access
// assumes step_i pulses once per counting clock and strobes last a cycle
`timescale 1ns/1ns
module stw_counter (
  // clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              rst_n_i,
  // counting
  input  wire logic              step_i,
  input  wire logic              gate_i,
  output logic                   out_o,
  // programming
  input  wire logic              ctrl_wr_i,
  input  wire stw_pkg::stw_ctrl_t ctrl_i,
  input  wire logic              latch_i,
  input  wire logic              data_wr_i,
  input  wire logic [7:0]        data_i,
  input  wire logic              data_rd_i,
  output logic [7:0]             rdata_o
);
  import stw_pkg::*;

  stw_ctrl_t   ctrl;
  logic [15:0] count;
  logic [15:0] init;
  logic [15:0] latch_val;
  logic        load_pend;
  logic        wr_hi;
  logic        rd_hi;
  logic        latched;
  logic        armed;
  logic        trig;
  logic        gate_q;
  logic        wr_done;
  logic        hw_trig_mode;
  logic [15:0] dec1;
  logic [15:0] dec2;
  logic [15:0] rsrc;

  function automatic logic [15:0] bcd_dec(input logic [15:0] v);
    logic [15:0] r;
    logic        brw;
    r   = v;
    brw = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (brw) begin
        if (v[i*4 +: 4] == 4'h0) begin
          r[i*4 +: 4] = 4'h9;
        end else begin
          r[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
          brw = 1'b0;
        end
      end
    end
    return r;
  endfunction : bcd_dec

  assign wr_done      = data_wr_i && (ctrl.rw != RW_BOTH || wr_hi);
  assign hw_trig_mode = ctrl.mode == MODE_ONESHOT ||
                        ctrl.mode == MODE_HW_STROBE;
  assign dec1         = ctrl.bcd ? bcd_dec(count) : count - 16'h0001;
  assign dec2         = ctrl.bcd ? bcd_dec(bcd_dec(count))
                                 : count - 16'h0002;

  // ==========================================================
  // programming and count writes
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl      <= '0;
      init      <= 16'h0000;
      wr_hi     <= 1'b0;
      load_pend <= 1'b0;
    end else begin
      if (ctrl_wr_i) begin
        ctrl      <= ctrl_i;
        wr_hi     <= 1'b0;
        load_pend <= 1'b0;
      end else if (data_wr_i) begin
        case (ctrl.rw)
          RW_LOW:  init <= {8'h00, data_i};
          RW_HIGH: init <= {data_i, 8'h00};
          default: begin
            if (wr_hi) begin
              init[15:8] <= data_i;
            end else begin
              init[7:0] <= data_i;
            end
            wr_hi <= ~wr_hi;
          end
        endcase
        if (wr_done) begin
          load_pend <= 1'b1;
        end
      end else if (step_i && (!armed || !hw_trig_mode || trig)) begin
        load_pend <= 1'b0;
      end
    end
  end

  // ==========================================================
  // output latch and count reads
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latched   <= 1'b0;
      latch_val <= 16'h0000;
      rd_hi     <= 1'b0;
    end else begin
      if (ctrl_wr_i) begin
        latched <= 1'b0;
        rd_hi   <= 1'b0;
      end else if (latch_i && !latched) begin
        latched   <= 1'b1;
        latch_val <= count;
      end else if (data_rd_i) begin
        if (ctrl.rw == RW_BOTH) begin
          rd_hi <= ~rd_hi;
        end
        if (ctrl.rw != RW_BOTH || rd_hi) begin
          latched <= 1'b0;
        end
      end
    end
  end

  assign rsrc    = latched ? latch_val : count;
  assign rdata_o = (ctrl.rw == RW_HIGH || (ctrl.rw == RW_BOTH && rd_hi))
                   ? rsrc[15:8] : rsrc[7:0];

  // ==========================================================
  // counting element
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count  <= 16'h0000;
      out_o  <= 1'b1;
      armed  <= 1'b0;
      trig   <= 1'b0;
      gate_q <= 1'b0;
    end else begin
      gate_q <= gate_i;
      if (gate_i && !gate_q) begin
        trig <= 1'b1;
      end
      if (ctrl_wr_i) begin
        armed <= 1'b0;
        out_o <= (ctrl_i.mode != MODE_TERM);
      end else if (data_wr_i && ctrl.mode == MODE_TERM &&
                   ctrl.rw == RW_BOTH && !wr_hi) begin
        armed <= 1'b0;
        out_o <= 1'b0;
      end else if (step_i) begin
        if ((load_pend && !hw_trig_mode &&
             (!armed || ctrl.mode == MODE_TERM ||
              ctrl.mode == MODE_SW_STROBE)) ||
            (hw_trig_mode && trig && (load_pend || armed))) begin
          count <= (ctrl.mode == MODE_SQUARE) ? (init & 16'hfffe) : init;
          armed <= 1'b1;
          trig  <= 1'b0;
          out_o <= (ctrl.mode != MODE_TERM && ctrl.mode != MODE_ONESHOT);
        end else if (armed && (gate_i || hw_trig_mode)) begin
          case (ctrl.mode)
            MODE_TERM, MODE_ONESHOT: begin
              count <= dec1;
              if (count == 16'h0001) begin
                out_o <= 1'b1;
              end
            end
            MODE_RATE: begin
              if (count == 16'h0001) begin
                count <= init;
                out_o <= 1'b1;
              end else begin
                count <= dec1;
                out_o <= (count != 16'h0002);
              end
            end
            MODE_SQUARE: begin
              if (count <= 16'h0002) begin
                count <= init & 16'hfffe;
                out_o <= ~out_o;
              end else begin
                count <= dec2;
              end
            end
            default: begin
              count <= dec1;
              out_o <= (count != 16'h0001);
              if (count == 16'h0000) begin
                armed <= 1'b0;
              end
            end
          endcase
        end else if (!gate_i &&
                     (ctrl.mode == MODE_RATE || ctrl.mode == MODE_SQUARE)) begin
          out_o <= 1'b1;
        end
      end
    end
  end

endmodule : stw_counter

// File: tb/stw_timer_sva.sv
// stw_timer_sva: port-level checks of the timer and watchdog block
// assumes it is bound onto stw_timer, one reference clock domain
`timescale 1ns/1ns
module stw_timer_sva (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // byte i/o port access
  input  wire logic [15:0] io_addr_i,
  input  wire logic [7:0]  io_wdata_i,
  input  wire logic        io_wr_i,
  input  wire logic        io_rd_i,
  input  wire logic [7:0]  io_rdata_o,
  // acknowledge and enable
  input  wire logic        inta_i,
  input  wire logic [7:0]  inta_vector_i,
  input  wire logic        wdog_en_i,
  // system outputs
  input  wire logic        tick_irq_o,
  input  wire logic        nmi_o,
  input  wire logic        write_block_o,
  input  wire logic        audio_o,
  input  wire logic        wdog_timeout_o
);
  import stw_pkg::*;

  logic mapped;
  logic spk;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // ==========================================================
  // helper logic
  assign mapped = io_addr_i inside {TICK_COUNT_PORT, TONE_COUNT_PORT,
    TICK_TONE_CTRL_PORT, WDOG_COUNT_PORT, WDOG_CTRL_PORT,
    SYS_CTRL_B_PORT, SYS_CTRL_A_PORT};

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      spk <= 1'b0;
    end else if (io_wr_i && io_addr_i == SYS_CTRL_B_PORT) begin
      spk <= io_wdata_i[B_SPKR_EN];
    end
  end

  // ==========================================================
  // sequences
  sequence s_port_clear;
    io_wr_i && io_addr_i == SYS_CTRL_B_PORT && io_wdata_i[B_IRQ_CLEAR];
  endsequence
  sequence s_ack_clear;
    inta_i && inta_vector_i == TICK_VECTOR;
  endsequence
  sequence s_irq_drop;
    ##[1:2] !tick_irq_o;
  endsequence
  sequence s_en_low2;
    !wdog_en_i ##1 !wdog_en_i;
  endsequence

  // ==========================================================
  // assertions
  irq_port_clear_a: assert property (s_port_clear |-> s_irq_drop)
    else $error("tick request kept after port clear");
  irq_ack_clear_a: assert property (s_ack_clear |-> s_irq_drop)
    else $error("tick request kept after acknowledge");
  nmi_gated_a: assert property (!wdog_en_i |=> !nmi_o)
    else $error("nmi while watchdog disabled");
  block_gated_a: assert property (s_en_low2 |=> !write_block_o)
    else $error("write block while watchdog disabled");
  timeout_clear_a: assert property (s_en_low2 |=> !wdog_timeout_o)
    else $error("timeout bit kept while disabled");
  block_pending_a: assert property (write_block_o |->
    tick_irq_o || $past(tick_irq_o))
    else $error("write block without pending request");
  rdata_hold_a: assert property (!io_rd_i |=> $stable(io_rdata_o))
    else $error("read data changed without read");
  unmapped_read_a: assert property (io_rd_i && !mapped |=>
    io_rdata_o == RDATA_RESET)
    else $error("unmapped read not zero");
  sysb_read_a: assert property (io_rd_i && io_addr_i == SYS_CTRL_B_PORT
    |=> (io_rdata_o & 8'hdc) == 8'h00)
    else $error("port b read has stray bits");
  sysa_read_a: assert property (io_rd_i && io_addr_i == SYS_CTRL_A_PORT
    |=> (io_rdata_o & 8'hef) == 8'h00)
    else $error("port a read has stray bits");
  audio_gated_a: assert property (!spk ##1 !spk |=> !audio_o)
    else $error("audio without speaker enable");

endmodule : stw_timer_sva

// File: tb/stw_host.sv
// stw_host: host processor model making byte i/o and acknowledge cycles
// assumes the timer block samples strobes on rising reference edges
`timescale 1ns/1ns
module stw_host (
  // clock
  input  wire logic        ref_clk_i,
  // read data
  input  wire logic [7:0]  io_rdata_i,
  // bus drive
  output logic      [15:0] io_addr_o,
  output logic      [7:0]  io_wdata_o,
  output logic             io_wr_o,
  output logic             io_rd_o,
  output logic             inta_o,
  output logic      [7:0]  inta_vector_o,
  output logic             wdog_en_o
);
  initial begin
    io_addr_o     = 16'h0000;
    io_wdata_o    = 8'h00;
    io_wr_o       = 1'b0;
    io_rd_o       = 1'b0;
    inta_o        = 1'b0;
    inta_vector_o = 8'h00;
    wdog_en_o     = 1'b0;
  end

  // ==========================================================
  // one whole access per call, released lines show inverse
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    io_addr_o  <= a;
    io_wdata_o <= d;
    io_wr_o    <= 1'b1;
    @(posedge ref_clk_i);
    io_wr_o    <= 1'b0;
    io_addr_o  <= ~a;
    io_wdata_o <= ~d;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    io_addr_o <= a;
    io_rd_o   <= 1'b1;
    @(posedge ref_clk_i);
    io_rd_o   <= 1'b0;
    io_addr_o <= ~a;
    #1;
    d = io_rdata_i;
  endtask : rd

  task automatic ack(input logic [7:0] v);
    @(posedge ref_clk_i);
    inta_o        <= 1'b1;
    inta_vector_o <= v;
    @(posedge ref_clk_i);
    inta_o        <= 1'b0;
    inta_vector_o <= ~v;
  endtask : ack

  task automatic set_en(input logic e);
    @(posedge ref_clk_i);
    wdog_en_o <= e;
  endtask : set_en

endmodule : stw_host

// File: tb/stw_timer_tb_top.sv
// stw_timer_tb_top: self-checking bench of the timer and watchdog block
// assumes the host model drives every bus input of the block
`timescale 1ns/1ns
module stw_timer_tb_top;
  import stw_pkg::*;

  logic        ref_clk_i;
  logic        rst_n_i;
  logic [15:0] io_addr_i;
  logic [7:0]  io_wdata_i;
  logic        io_wr_i;
  logic        io_rd_i;
  logic [7:0]  io_rdata_o;
  logic        inta_i;
  logic [7:0]  inta_vector_i;
  logic        wdog_en_i;
  logic        tick_irq_o;
  logic        nmi_o;
  logic        write_block_o;
  logic        audio_o;
  logic        wdog_timeout_o;
  int          num_errors = 0;
  int          n_checks = 0;

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  stw_host u_stw_host (.ref_clk_i, .io_rdata_i(io_rdata_o),
    .io_addr_o(io_addr_i), .io_wdata_o(io_wdata_i), .io_wr_o(io_wr_i),
    .io_rd_o(io_rd_i), .inta_o(inta_i), .inta_vector_o(inta_vector_i),
    .wdog_en_o(wdog_en_i));

  stw_timer u_stw_timer (.ref_clk_i, .rst_n_i, .io_addr_i, .io_wdata_i,
    .io_wr_i, .io_rd_i, .io_rdata_o, .inta_i, .inta_vector_i, .wdog_en_i,
    .tick_irq_o, .nmi_o, .write_block_o, .audio_o, .wdog_timeout_o);

  // ==========================================================
  // helpers
  function automatic logic [7:0] cw(input logic [1:0] sel, rw,
                                    input logic [2:0] mode);
    return {sel, rw, mode, 1'b0};
  endfunction : cw

  function automatic logic sig(input int s);
    case (s)
      0: return tick_irq_o;
      1: return nmi_o;
      2: return write_block_o;
      3: return audio_o;
      default: return wdog_timeout_o;
    endcase
  endfunction : sig

  task automatic chk_byte(input logic [7:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk_bit

  task automatic wait_sig(input int s, input logic v, input int lim,
                          input string m);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge ref_clk_i);
      #1;
      if (sig(s) === v) break;
    end
    chk_bit(sig(s), v, m);
  endtask : wait_sig

  task automatic end_sim;
    if (num_errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (60000) @(posedge ref_clk_i);
    num_errors++;
    end_sim();
  end

  // ==========================================================
  // tests
  initial begin
    logic [7:0] d;
    logic [7:0] v;
    logic [1:0] seen;
    int         k;
    rst_n_i = 1'b0;
    void'($urandom(32'h44f1));
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    #1;
    for (k = 0; k < 5; k++) chk_bit(sig(k), 1'b0, "reset output");
    // tick channel, rate mode, count 4
    u_stw_host.wr(TICK_TONE_CTRL_PORT, cw(SEL_TICK, RW_BOTH, MODE_RATE));
    u_stw_host.wr(TICK_COUNT_PORT, 8'h04);
    u_stw_host.wr(TICK_COUNT_PORT, 8'h00);
    wait_sig(0, 1'b1, 1500, "no tick request");
    u_stw_host.wr(SYS_CTRL_B_PORT, 8'h80);
    wait_sig(0, 1'b0, 3, "port clear failed");
    wait_sig(0, 1'b1, 1500, "no second tick");
    v = 8'($urandom);
    if (v == TICK_VECTOR) v = 8'h09;
    u_stw_host.ack(v);
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk_bit(tick_irq_o, 1'b1, "other vector cleared");
    u_stw_host.ack(TICK_VECTOR);
    wait_sig(0, 1'b0, 3, "vector clear failed");
    // tone latch, reload and interleaved reads, gate low
    u_stw_host.wr(TICK_TONE_CTRL_PORT, cw(SEL_TONE, RW_BOTH, MODE_TERM));
    u_stw_host.wr(TONE_COUNT_PORT, 8'h34);
    u_stw_host.wr(TONE_COUNT_PORT, 8'h12);
    repeat (200) @(posedge ref_clk_i);
    u_stw_host.wr(TICK_TONE_CTRL_PORT, cw(SEL_TONE, RW_LATCH, 3'h0));
    u_stw_host.wr(TONE_COUNT_PORT, 8'h78);
    u_stw_host.wr(TONE_COUNT_PORT, 8'h56);
    repeat (200) @(posedge ref_clk_i);
    u_stw_host.wr(TICK_TONE_CTRL_PORT, cw(SEL_TONE, RW_LATCH, 3'h0));
    u_stw_host.rd(TONE_COUNT_PORT, d);
    chk_byte(d, 8'h34, "latched low");
    u_stw_host.rd(TICK_COUNT_PORT, v);
    u_stw_host.rd(TONE_COUNT_PORT, d);
    chk_byte(d, 8'h12, "latched high");
    u_stw_host.wr(TICK_TONE_CTRL_PORT, cw(SEL_TONE, RW_LATCH, 3'h0));
    u_stw_host.rd(TONE_COUNT_PORT, d);
    chk_byte(d, 8'h78, "new count low");
    u_stw_host.rd(TONE_COUNT_PORT, d);
    chk_byte(d, 8'h56, "new count high");
    // single byte formats with random data
    for (k = 0; k < 4; k++) begin
      d = 8'($urandom);
      u_stw_host.wr(TICK_TONE_CTRL_PORT,
        cw(SEL_TONE, k[0] ? RW_HIGH : RW_LOW, MODE_TERM));
      u_stw_host.wr(TONE_COUNT_PORT, d);
      repeat (200) @(posedge ref_clk_i);
      u_stw_host.wr(TICK_TONE_CTRL_PORT, cw(SEL_TONE, RW_LATCH, 3'h0));
      u_stw_host.rd(TONE_COUNT_PORT, v);
      chk_byte(v, d, "byte format");
    end
    // tone out and speaker path
    u_stw_host.wr(TICK_TONE_CTRL_PORT, cw(SEL_TONE, RW_LOW, MODE_SQUARE));
    u_stw_host.wr(TONE_COUNT_PORT, 8'h08);
    u_stw_host.wr(SYS_CTRL_B_PORT, 8'h03);
    wait_sig(3, 1'b1, 2000, "no audio");
    seen = 2'h0;
    for (k = 0; k < 80; k++) begin
      u_stw_host.rd(SYS_CTRL_B_PORT, d);
      seen[d[B_TONE_OUT]] = 1'b1;
      repeat (10) @(posedge ref_clk_i);
    end
    chk_byte({6'h0, seen}, 8'h03, "tone bit not toggling");
    chk_byte(d & 8'h03, 8'h03, "stored port bits");
    u_stw_host.wr(SYS_CTRL_B_PORT, 8'h01);
    wait_sig(3, 1'b0, 3, "audio kept");
    // watchdog with unserviced tick requests
    u_stw_host.wr(WDOG_CTRL_PORT, cw(SEL_WDOG, RW_LOW, MODE_TERM));
    u_stw_host.wr(WDOG_COUNT_PORT, 8'h02);
    u_stw_host.set_en(1'b1);
    wait_sig(2, 1'b1, 3000, "no write block");
    u_stw_host.wr(TICK_COUNT_PORT, 8'hff);
    u_stw_host.wr(TICK_COUNT_PORT, 8'hff);
    wait_sig(1, 1'b1, 4000, "no nmi");
    wait_sig(4, 1'b1, 3, "no timeout bit");
    u_stw_host.rd(SYS_CTRL_A_PORT, d);
    chk_byte(d, 8'h10, "port a timeout");
    u_stw_host.wr(SYS_CTRL_B_PORT, 8'h80);
    wait_sig(2, 1'b0, 3, "block kept");
    wait_sig(0, 1'b1, 500, "tick lost");
    u_stw_host.wr(SYS_CTRL_B_PORT, 8'h80);
    wait_sig(0, 1'b1, 500, "blocked count taken");
    u_stw_host.set_en(1'b0);
    wait_sig(1, 1'b0, 4, "nmi kept");
    wait_sig(4, 1'b0, 4, "timeout kept");
    u_stw_host.wr(16'h0050, 8'h5a);
    u_stw_host.rd(16'h0050, d);
    chk_byte(d, RDATA_RESET, "unmapped read");
    end_sim();
  end

endmodule : stw_timer_tb_top

bind stw_timer stw_timer_sva u_stw_timer_sva (.ref_clk_i, .rst_n_i,
  .io_addr_i, .io_wdata_i, .io_wr_i, .io_rd_i, .io_rdata_o, .inta_i,
  .inta_vector_i, .wdog_en_i, .tick_irq_o, .nmi_o, .write_block_o,
  .audio_o, .wdog_timeout_o);
